// ---- core/video_host_tx.sv ----
// video packet transmitter: sequences sync, blanking and pixel symbols
// per line and frame, controlled over apb.
// assumes one clk, synchronous nrst, the receiver on the link interface.
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/100ps
// Operation
// - transmitter offers pulse, event and burst sequences
// - receiver accepts sequences without extra constraints
// - frame starts vsync start, others end/hsync
// - pixels never split across packets
// - zero porch drops its blanking packet
// - low power at least per frame
// - blanking interval may idle low power
// - receiver replies only after a turnaround
// - any packet order inside blanking accepted
// - pulse mode sends sync start and end; the first line sends no hsync end
// - pulse mode fills periods with blanking
// - long blanking may become low power
// - pulse mode keeps sync widths with end packets; first line sends no hsync end, receiver caps widths at its regen counts
// - event mode sends starts, receiver regenerates
// - burst compresses pixels then blanking/low power
// - receiver bounds reply length
// - clock and data ordering honoured
// - timing limits come from registers
module video_host_tx (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    video_link_if.host link
);
    import video_link_pkg::*;

    // line sequencer states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_LEAD = 7'h02,
        ST_HSYNC = 7'h04,
        ST_HSEND = 7'h08,
        ST_HBACK = 7'h10,
        ST_ACTIVE = 7'h20,
        ST_HFRONT = 7'h40
    } hstate_t;

    // whole state of the transmitter
    typedef struct packed {
        hstate_t st;
        logic [DIV_W-1:0] div;
        logic linkClk;
        pkt_t pkt;
        logic lp;
        logic grant;
        logic [7:0] cnt; // symbols left in the current period
        logic [LINE_W-1:0] line;
        logic en;
        logic [1:0] mode;
        logic lpBlank;
        logic turnReq;
        logic [31:0] htime;
        logic [31:0] vtime;
        logic rvValid; // sticky, cleared by a status read
        logic [7:0] rvData;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } host_reg_t;

    host_reg_t r_q;
    host_reg_t r_d;
    logic [9:0] rvSync; // {valid, done, data}
    logic [7:0] hSync, hBack, active_pixels_per_line, hFront;
    logic [LINE_W-1:0] vActStart, vActEnd, vTotal;
    logic [7:0] pixTicks;
    logic activeLine, fallTick, riseTick, pulse;

    // reverse wires come from the receiver's domain
    link_sync #(.W(10)) uRvSync (
        .clk(clk),
        .nrst(nrst),
        .d({link.rvValid, link.rvDone, link.rvData}),
        .q(rvSync)
    );

    // timing fields
    assign hSync = r_q.htime[SYNC_LSB +: TIME_W];
    assign hBack = r_q.htime[BACK_LSB +: TIME_W];
    assign active_pixels_per_line = r_q.htime[ACT_LSB +: TIME_W];
    assign hFront = r_q.htime[FRONT_LSB +: TIME_W];
    // vertical regions in order sync, back, active, front
    assign vActStart = LINE_W'(r_q.vtime[SYNC_LSB +: TIME_W]) + LINE_W'(r_q.vtime[BACK_LSB +: TIME_W]);
    assign vActEnd = vActStart + LINE_W'(r_q.vtime[ACT_LSB +: TIME_W]);
    assign vTotal = vActEnd + LINE_W'(r_q.vtime[FRONT_LSB +: TIME_W]);
    assign activeLine = (r_q.line >= vActStart) && (r_q.line < vActEnd);
    assign pulse = (r_q.mode == MODE_PULSE);
    // burst squeezes pixels into fewer symbols, never to zero
    assign pixTicks = (r_q.mode != MODE_BURST) ? active_pixels_per_line :
        (((active_pixels_per_line >> BURST_SHIFT) == 8'h00) && (active_pixels_per_line != 8'h00)) ? 8'h01 : (active_pixels_per_line >> BURST_SHIFT);
    // symbols change as linkClk falls, receiver samples on the rise
    assign fallTick = (r_q.div == DIV_W'(LINK_HALF_CYC - 1)) && r_q.linkClk;
    assign riseTick = (r_q.div == DIV_W'(LINK_HALF_CYC - 1)) && !r_q.linkClk;

    // period length of a state
    function automatic logic [7:0] lenOf(input hstate_t s, input logic [7:0] hs, input logic [7:0] hb,
            input logic [7:0] ha, input logic [7:0] hf);
        case (s)
            ST_HSYNC: lenOf = hs;
            ST_HBACK: lenOf = hb;
            ST_ACTIVE: lenOf = ha;
            ST_HFRONT: lenOf = hf;
            default: lenOf = 8'h01;
        endcase
    endfunction

    // next period within a line
    function automatic hstate_t succ(input hstate_t s, input logic isPulse, input logic firstLine);
        case (s)
            ST_LEAD: succ = isPulse ? ST_HSYNC : ST_HBACK;
            ST_HSYNC: succ = firstLine ? ST_HBACK : ST_HSEND;
            ST_HSEND: succ = ST_HBACK;
            ST_HBACK: succ = ST_ACTIVE;
            ST_ACTIVE: succ = ST_HFRONT;
            default: succ = ST_LEAD;
        endcase
    endfunction

    // sequencer, symbol builder and register file
    always_comb begin
        hstate_t nst;
        logic [7:0] len;
        logic [LINE_W-1:0] nline;
        logic bllpLp;
        nst = r_q.st;
        len = 8'h00;
        nline = r_q.line;
        bllpLp = 1'b0;
        r_d = r_q;
        // link clock divider, the transmitter owns the link clock
        if (r_q.div == DIV_W'(LINK_HALF_CYC - 1)) begin
            r_d.div = '0;
            r_d.linkClk = !r_q.linkClk;
        end else begin
            r_d.div = r_q.div + DIV_W'(1);
        end
        // new symbol on every falling link edge
        if (fallTick) begin
            if (r_q.st == ST_IDLE) begin
                if (r_q.en) begin
                    nst = ST_LEAD;
                    nline = '0;
                end
            end else if (r_q.cnt > 8'h01) begin
                r_d.cnt = r_q.cnt - 8'h01;
            end else begin
                nst = succ(r_q.st, pulse, r_q.line == '0);
                // zero length periods are dropped
                for (int i = 0; i < 4; i++) begin
                    if (nst != ST_LEAD && nst != ST_HSEND &&
                            lenOf(nst, hSync, hBack, active_pixels_per_line, hFront) == 8'h00) begin
                        nst = succ(nst, pulse, r_q.line == '0);
                    end
                end
                if (nst == ST_LEAD) begin
                    // line count wraps at the frame end
                    nline = (r_q.line + LINE_W'(1) >= vTotal) ? '0 : r_q.line + LINE_W'(1);
                    if (!r_q.en) begin
                        nst = ST_IDLE;
                    end
                end
            end
            if (nst != r_q.st || r_q.st == ST_IDLE) begin
                len = lenOf(nst, hSync, hBack, active_pixels_per_line, hFront);
                r_d.cnt = len;
            end else begin
                len = r_q.cnt;
            end
            r_d.st = nst;
            r_d.line = nline;
            // blanking becomes low power when allowed and long enough
            bllpLp = r_q.lpBlank && (lenOf(nst, hSync, hBack, active_pixels_per_line, hFront) >= LP_MIN_SYMBOLS);
            r_d.lp = 1'b0;
            r_d.pkt = PKT_NONE;
            case (nst)
                ST_IDLE: begin
                    r_d.lp = 1'b1;
                    r_d.grant = 1'b0;
                end
                ST_LEAD: begin
                    // first line vsync start, else vsync end or hsync start
                    if (nline == '0) begin
                        r_d.pkt = PKT_VSYNC_START;
                    end else if (pulse && nline == LINE_W'(r_q.vtime[SYNC_LSB +: TIME_W])) begin
                        r_d.pkt = PKT_VSYNC_END;
                    end else begin
                        r_d.pkt = PKT_HSYNC_START;
                    end
                end
                ST_HSEND: begin
                    r_d.pkt = PKT_HSYNC_END;
                end
                ST_ACTIVE: begin
                    if (nline >= vActStart && nline < vActEnd) begin
                        // one pixel group per symbol, never split
                        if (r_d.cnt > active_pixels_per_line - pixTicks) begin
                            r_d.pkt = PKT_PIXELS;
                        end else if (r_q.lpBlank) begin
                            r_d.lp = 1'b1;
                        end else begin
                            r_d.pkt = PKT_BLANKING;
                        end
                    end else begin
                        // vertical blanking line idles in low power
                        r_d.lp = 1'b1;
                        if (r_q.st != ST_ACTIVE && r_q.turnReq) begin
                            r_d.grant = 1'b1;
                            r_d.turnReq = 1'b0;
                        end
                    end
                end
                default: begin
                    // sync and porch periods
                    if (bllpLp) begin
                        r_d.lp = 1'b1;
                    end else begin
                        r_d.pkt = PKT_BLANKING;
                    end
                end
            endcase
            // bus comes back when the active period ends, timing first
            if (nst != ST_ACTIVE) begin
                r_d.grant = 1'b0;
            end
        end
        // reverse traffic sampled once per symbol
        if (riseTick && r_q.grant) begin
            if (rvSync[9]) begin
                r_d.rvValid = 1'b1;
                r_d.rvData = rvSync[7:0];
            end
            if (rvSync[8]) begin
                r_d.grant = 1'b0; // receiver is done
            end
        end
        // apb: answer in the first access cycle
        r_d.pready = psel && !penable;
        r_d.pslverr = 1'b0;
        r_d.prdata = '0;
        if (psel && !penable) begin
            case (paddr)
                OFS_CTRL: r_d.prdata = {27'h0, r_q.turnReq, r_q.lpBlank, r_q.mode, r_q.en};
                OFS_HTIME: r_d.prdata = r_q.htime;
                OFS_VTIME: r_d.prdata = r_q.vtime;
                OFS_STATUS: begin
                    r_d.prdata[STAT_LINE_LSB +: LINE_W] = r_q.line;
                    r_d.prdata[STAT_RUN_BIT] = (r_q.st != ST_IDLE);
                    r_d.prdata[STAT_GRANT_BIT] = r_q.grant;
                    r_d.prdata[STAT_RV_BIT] = r_q.rvValid;
                    r_d.prdata[STAT_RVDATA_LSB +: 8] = r_q.rvData;
                end
                default: r_d.pslverr = 1'b1;
            endcase
            if (pwrite) begin
                r_d.prdata = '0;
            end
        end
        if (psel && penable && r_q.pready) begin
            if (pwrite) begin
                case (paddr)
                    OFS_CTRL: begin
                        r_d.en = pwdata[CTRL_EN_BIT];
                        r_d.mode = pwdata[CTRL_MODE_LSB +: 2];
                        r_d.lpBlank = pwdata[CTRL_LPBLANK_BIT];
                        // a new request outranks the one just consumed
                        if (pwdata[CTRL_TURN_BIT]) begin
                            r_d.turnReq = 1'b1;
                        end
                    end
                    OFS_HTIME: r_d.htime = pwdata;
                    OFS_VTIME: r_d.vtime = pwdata;
                    default: ;
                endcase
            end else if (paddr == OFS_STATUS) begin
                // read clears, but a byte landing now wins
                if (!(riseTick && r_q.grant && rvSync[9])) begin
                    r_d.rvValid = 1'b0;
                end
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_q <= '0;
            r_q.st <= ST_IDLE;
            r_q.lp <= 1'b1;
            r_q.htime <= HTIME_RST;
            r_q.vtime <= VTIME_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // every output straight from the state register
    assign prdata = r_q.prdata;
    assign pready = r_q.pready;
    assign pslverr = r_q.pslverr;
    assign link.linkClk = r_q.linkClk;
    assign link.pkt = r_q.pkt;
    assign link.lp = r_q.lp;
    assign link.grant = r_q.grant;
endmodule // video_host_tx

// ---- core/video_link_pkg.sv ----
// shared constants for the video packet link: packet codes, modes,
// register map of the transmitter, link timing.
// assumes both ends run on one 20 MHz clock each.
package video_link_pkg;
    // clock figures
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINK_PERIOD_NS = 400;
    // half link period in clk cycles, rounded down, not clamped, 4 here
    localparam int LINK_HALF_CYC = (LINK_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int DIV_W = $clog2(LINK_HALF_CYC) + 1;

    // one symbol per link period carries one packet code
    typedef enum logic [2:0] {
        PKT_NONE = 3'h0,
        PKT_VSYNC_START = 3'h1,
        PKT_VSYNC_END = 3'h2,
        PKT_HSYNC_START = 3'h3,
        PKT_HSYNC_END = 3'h4,
        PKT_BLANKING = 3'h5,
        PKT_PIXELS = 3'h6
    } pkt_t;

    // sequence modes
    localparam logic [1:0] MODE_PULSE = 2'h0;
    localparam logic [1:0] MODE_EVENT = 2'h1;
    localparam logic [1:0] MODE_BURST = 2'h2;

    // register offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_HTIME = 8'h04;
    localparam logic [7:0] OFS_VTIME = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;

    // control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int CTRL_LPBLANK_BIT = 3;
    localparam int CTRL_TURN_BIT = 4;

    // timing fields, one byte each, same layout in both timing words
    localparam int TIME_W = 8;
    localparam int SYNC_LSB = 0;
    localparam int BACK_LSB = 8;
    localparam int ACT_LSB = 16;
    localparam int FRONT_LSB = 24;
    localparam logic [31:0] HTIME_RST = 32'h04_20_04_02;
    localparam logic [31:0] VTIME_RST = 32'h02_08_02_01;

    // status fields
    localparam int LINE_W = 10;
    localparam int STAT_LINE_LSB = 0;
    localparam int STAT_RUN_BIT = 12;
    localparam int STAT_GRANT_BIT = 13;
    localparam int STAT_RV_BIT = 14;
    localparam int STAT_RVDATA_LSB = 16;

    // symbols needed to leave high speed and come back
    localparam logic [7:0] LP_MIN_SYMBOLS = 8'h02;
    localparam int BURST_SHIFT = 1;
    // longest reply of the receiver per turnaround, in symbols
    localparam logic [2:0] REPLY_MAX = 3'h4;
endpackage

// ---- core/video_link_if.sv ----
// link wires between the transmitter and the display receiver.
// assumes the transmitter makes linkClk; reverse wires are receiver driven.
`timescale 1ns/100ps
interface video_link_if;
    import video_link_pkg::*;
    logic linkClk; // symbol clock from the transmitter
    pkt_t pkt; // packet code of the current symbol
    logic lp; // lanes in low power idle
    logic grant; // bus handed to the receiver
    logic rvValid; // reverse byte present
    logic [7:0] rvData; // reverse byte
    logic rvDone; // receiver hands the bus back

    modport host (output linkClk, output pkt, output lp, output grant,
        input rvValid, input rvData, input rvDone);
    modport periph (input linkClk, input pkt, input lp, input grant,
        output rvValid, output rvData, output rvDone);
endinterface

// ---- core/link_sync.sv ----
// two flip-flop synchroniser for signals crossing into clk.
// assumes multi-bit inputs stay steady for many clk cycles.
`timescale 1ns/100ps
module link_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    // both stages in one state word
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;
    sync_t r_q;
    sync_t r_d;

    // first stage feeds only the second
    always_comb begin
        r_d = r_q;
        r_d.s1 = d;
        r_d.s2 = r_q.s1;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign q = r_q.s2;
endmodule // link_sync

// ---- core/video_periph_rx.sv ----
// display receiver: rebuilds sync, line and pixel timing from link
// symbols and replies when handed the bus.
// assumes linkClk from the transmitter, slower than clk by at least 4x.
`timescale 1ns/100ps
module video_periph_rx #(
    parameter logic [7:0] HSYNC_REGEN = 8'h04, // symbols of a regenerated hsync
    parameter logic [7:0] VSYNC_REGEN = 8'h02 // lines of a regenerated vsync
) (
    input wire logic clk,
    input wire logic nrst,
    video_link_if.periph link,
    input wire logic replyReq,
    input wire logic [7:0] replyData,
    output logic replyAck,
    output logic vsyncOut,
    output logic hsyncOut,
    output logic pixelEnable,
    output logic lineStart,
    output logic frameStart,
    output logic lpSeen,
    output video_link_pkg::pkt_t lastPkt,
    output logic [video_link_pkg::LINE_W-1:0] lineCount
);
    import video_link_pkg::*;

    // whole state of the receiver
    typedef struct packed {
        logic prevClk;
        logic vsync;
        logic hsync;
        logic pixEn;
        logic lineStart;
        logic frameStart;
        logic lpSeen;
        pkt_t lastPkt;
        logic [7:0] hCnt;
        logic [7:0] vCnt;
        logic [LINE_W-1:0] line;
        logic rvValid;
        logic [7:0] rvData;
        logic rvDone;
        logic [2:0] replyCnt;
        logic replyAck;
    } rx_reg_t;

    rx_reg_t r_q;
    rx_reg_t r_d;
    logic [5:0] inSync; // {clk, pkt, lp, grant}
    logic lClk, rise, fall, grant;
    pkt_t pkt;

    // every link input passes two flops first
    link_sync #(.W(6)) uInSync (
        .clk(clk),
        .nrst(nrst),
        .d({link.linkClk, link.pkt, link.lp, link.grant}),
        .q(inSync)
    );
    assign lClk = inSync[5];
    assign pkt = pkt_t'(inSync[4:2]);
    assign grant = inSync[0];
    assign rise = lClk && !r_q.prevClk;
    assign fall = !lClk && r_q.prevClk;

    // symbol decode and reply
    always_comb begin
        r_d = r_q;
        r_d.prevClk = lClk;
        r_d.lineStart = 1'b0;
        r_d.frameStart = 1'b0;
        r_d.replyAck = 1'b0;
        if (rise) begin
            r_d.lastPkt = pkt;
            r_d.lpSeen = inSync[1];
            r_d.pixEn = (pkt == PKT_PIXELS);
            // hsync regenerated when no end packet arrives
            if (r_q.hsync && r_q.hCnt > 8'h01) begin
                r_d.hCnt = r_q.hCnt - 8'h01;
            end else begin
                r_d.hsync = 1'b0;
            end
            // any order of the other packets is taken as it comes
            case (pkt)
                PKT_VSYNC_START: begin
                    r_d.vsync = 1'b1;
                    r_d.vCnt = VSYNC_REGEN;
                    r_d.hsync = 1'b1;
                    r_d.hCnt = HSYNC_REGEN;
                    r_d.line = '0;
                    r_d.lineStart = 1'b1;
                    r_d.frameStart = 1'b1;
                end
                PKT_VSYNC_END, PKT_HSYNC_START: begin
                    r_d.hsync = 1'b1;
                    r_d.hCnt = HSYNC_REGEN;
                    r_d.line = r_q.line + LINE_W'(1);
                    r_d.lineStart = 1'b1;
                    // vsync ends on its packet or after the regen count
                    if (pkt == PKT_VSYNC_END || r_q.vCnt <= 8'h01) begin
                        r_d.vsync = 1'b0;
                    end else begin
                        r_d.vCnt = r_q.vCnt - 8'h01;
                    end
                end
                PKT_HSYNC_END: r_d.hsync = 1'b0;
                default: ;
            endcase
        end
        // reply only while the bus is handed over
        if (!grant) begin
            r_d.rvValid = 1'b0;
            r_d.rvDone = 1'b0;
            r_d.replyCnt = '0;
        end else if (fall && !r_q.rvDone) begin
            // bounded reply keeps the line buffer fed
            if (replyReq && r_q.replyCnt < REPLY_MAX) begin
                r_d.rvValid = 1'b1;
                r_d.rvData = replyData;
                r_d.replyCnt = r_q.replyCnt + 3'h1;
                r_d.replyAck = 1'b1;
            end else begin
                r_d.rvValid = 1'b0;
                r_d.rvDone = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (!nrst) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign replyAck = r_q.replyAck;
    assign vsyncOut = r_q.vsync;
    assign hsyncOut = r_q.hsync;
    assign pixelEnable = r_q.pixEn;
    assign lineStart = r_q.lineStart;
    assign frameStart = r_q.frameStart;
    assign lpSeen = r_q.lpSeen;
    assign lastPkt = r_q.lastPkt;
    assign lineCount = r_q.line;
    assign link.rvValid = r_q.rvValid;
    assign link.rvData = r_q.rvData;
    assign link.rvDone = r_q.rvDone;
endmodule // video_periph_rx

// ---- tb/video_link_sva.sv ----
// checker on the link wires between transmitter and receiver
// assumes one clk samples every wire, nrst synchronous active low
`timescale 1ns/100ps
module video_link_sva (
    input wire logic clk,
    input wire logic nrst,
    input wire logic linkClk,
    input wire video_link_pkg::pkt_t pkt,
    input wire logic lp,
    input wire logic grant,
    input wire logic rvValid,
    input wire logic [7:0] rvData,
    input wire logic rvDone
);
    import video_link_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    logic grant_q; // grant one cycle ago
    logic lc_q; // link clock one cycle ago
    logic [3:0] rvCnt_q; // bytes sent in this grant, wide so it cannot wrap
    // count one byte per link rise, since valid may stay high across bytes
    always_ff @(posedge clk) begin
        grant_q <= grant;
        lc_q <= linkClk;
        if (!nrst || (grant && !grant_q)) rvCnt_q <= 4'h0;
        else if (linkClk && !lc_q && rvValid) rvCnt_q <= rvCnt_q + 4'h1;
    end
    sequence sHighHalf; linkClk [*4] ##1 !linkClk; endsequence
    sequence sLowHalf; !linkClk [*4] ##1 linkClk; endsequence
    AST_LINK_HIGH: assert property ($rose(linkClk) |-> sHighHalf)
        else $error("link clock high half not 4 cycles");
    AST_LINK_LOW: assert property ($fell(linkClk) |-> sLowHalf)
        else $error("link clock low half not 4 cycles");
    AST_SYMBOL_HOLD: assert property (!$stable(pkt) |=> $stable(pkt) [*7])
        else $error("symbol shorter than one link period");
    AST_PKT_IN_LOW: assert property (!$stable(pkt) |-> !linkClk)
        else $error("symbol changed while link clock high");
    AST_LP_QUIET: assert property (lp |-> pkt == PKT_NONE)
        else $error("symbol sent while lanes in low power");
    AST_GRANT_LP: assert property (grant |-> lp)
        else $error("bus handed over outside low power");
    AST_RV_GRANT: assert property ((!grant) [*8] |-> !rvValid)
        else $error("reply byte without turnaround");
    AST_REPLY_MAX: assert property (rvCnt_q <= {1'b0, REPLY_MAX})
        else $error("too many reply bytes in one grant");
endmodule // video_link_sva

// ---- tb/tb_video_mode_packet_sequencer.sv ----
// bench: transmitter and receiver back to back, driven over apb
// assumes 20 MHz clk; receiver reply data fed by the bench
`timescale 1ns/100ps
module tb_video_mode_packet_sequencer;
    import video_link_pkg::*;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, e;
    logic lc_q = 1'b0;
    logic replyReq = 1'b1;
    logic replyAck, vsyncOut, hsyncOut, pixelEnable, lineStart, frameStart, lpSeen;
    logic [7:0] paddr, replyData;
    logic [31:0] pwdata, prdata, rd;
    pkt_t lastPkt;
    logic [LINE_W-1:0] lineCount;
    int error_cnt = 0, comparisons = 0, nVss = 0, n;
    int cnt[8], snap[8]; // symbols per code: running frame, last full frame
    video_link_if link();
    video_host_tx video_host_tx_inst(.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
    video_periph_rx video_periph_rx_inst(.clk(clk), .nrst(nrst), .link(link), .replyReq(replyReq),
        .replyData(replyData), .replyAck(replyAck), .vsyncOut(vsyncOut), .hsyncOut(hsyncOut),
        .pixelEnable(pixelEnable), .lineStart(lineStart), .frameStart(frameStart), .lpSeen(lpSeen),
        .lastPkt(lastPkt), .lineCount(lineCount));
    video_link_sva video_link_sva_inst(.clk(clk), .nrst(nrst), .linkClk(link.linkClk), .pkt(link.pkt),
        .lp(link.lp), .grant(link.grant), .rvValid(link.rvValid), .rvData(link.rvData), .rvDone(link.rvDone));
    // free running clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic print_verdict;
        if (error_cnt == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge: back to back calls never drive psel twice at once
        @(posedge clk);
        if (t >= 20) begin
            error_cnt++;
            $display("[FAIL] %0t apb no ready", $time);
            print_verdict();
        end
    endtask
    // wait for k frame starts on the wire, bounded
    task automatic frames(input int k);
        int n0, t;
        n0 = nVss;
        t = 0;
        while (nVss < n0 + k) begin
            @(posedge clk);
            t++;
            if (t > 20000) begin
                error_cnt++;
                $display("[FAIL] %0t no frame", $time);
                print_verdict();
            end
        end
    endtask
    // tally symbols at each link clock rise; frame boundary at vsync start
    always @(posedge clk) begin
        lc_q <= link.linkClk;
        if (replyAck === 1'b1) replyReq <= 1'b0; // one byte only, so the sticky flag stays clear after a read
        if (frameStart === 1'b1) chk({21'h0, lineCount, vsyncOut}, 32'h1);
        if (lineStart === 1'b1) chk({31'h0, hsyncOut}, 32'h1);
        if (pixelEnable === 1'b1) chk({29'h0, lastPkt}, {29'h0, PKT_PIXELS});
        if (link.linkClk && !lc_q) begin
            if (link.pkt == PKT_VSYNC_START) begin
                snap = cnt;
                cnt = '{default: 0};
                nVss++;
            end
            cnt[link.pkt]++;
        end
    end
    initial begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
        replyData = 8'hA5; cnt = '{default: 0}; snap = '{default: 0};
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFS_HTIME, 32'h0); chk(rd, HTIME_RST);
        apb(1'b0, OFS_VTIME, 32'h0); chk(rd, VTIME_RST);
        apb(1'b0, 8'h10, 32'h0); chk({e, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, OFS_HTIME, 32'h0204_0202);
        apb(1'b1, OFS_VTIME, 32'h0102_0101);
        // every mode; low power blanking in pulse and burst
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, OFS_CTRL, 32'h0);
            apb(1'b1, OFS_CTRL, 32'(m * 2 + 1 + (m != 1) * 8));
            frames(3);
            chk(snap[PKT_VSYNC_START], 32'h1);
            chk(snap[PKT_PIXELS], m == 2 ? 4 : 8);
            chk(snap[PKT_HSYNC_END], m == 0 ? 4 : 0);
            chk(snap[PKT_VSYNC_END], m == 0 ? 1 : 0);
            chk(snap[PKT_HSYNC_START], m == 0 ? 3 : 4);
        end
        apb(1'b0, OFS_STATUS, 32'h0); chk({rd[STAT_RV_BIT], rd[STAT_RUN_BIT]}, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h1D);
        n = 0;
        do begin
            apb(1'b0, OFS_STATUS, 32'h0);
            n++;
        end while (rd[STAT_RV_BIT] !== 1'b1 && n < 1000);
        chk(rd[STAT_RVDATA_LSB +: 8], 32'hA5);
        apb(1'b0, OFS_STATUS, 32'h0); chk(rd[STAT_RV_BIT], 32'h0);
        print_verdict();
    end
endmodule // tb_video_mode_packet_sequencer
